// [dv/wdg_checker.sv]
// concurrent checks on the ports of the watchdog top module
`timescale 1ns/1ps
`include "wdg_defines.vh"
module wdg_checker
(
   input logic I_REF_CLK, // clock
   input logic I_RESET_N, // reset, active low
   input logic I_PSEL, // apb select
   input logic I_PENABLE, // apb access phase
   input logic I_PWRITE, // apb direction
   input logic [`WDG_ADDR_W-1:0] I_PADDR, // apb address
   input logic [31:0] I_PWDATA, // apb write data
   input logic I_WD_OSC, // oscillator pin
   input logic O_PSLVERR, // apb error
   input logic [31:0] O_PRDATA, // apb read data
   input logic O_WD_IRQ, // interrupt request
   input logic O_SYS_RESET, // system reset pulse
   input logic [`WDG_ADDR_W-1:0] O_RESET_VECTOR, // reset vector
   input logic [`WDG_ADDR_W-1:0] O_TIMEOUT_VECTOR // time-out vector
);
   logic acc, rd, mapped, clr, flag_reg, flag_view;
   assign acc = I_PSEL && I_PENABLE;
   assign rd = acc && !I_PWRITE;
   assign mapped = I_PADDR == 12'h000 || I_PADDR == 12'h004 || I_PADDR == 12'h008;
   assign clr = acc && I_PWRITE && I_PADDR == 12'h004 && !I_PWDATA[3];
   // the flag shows together with the reset pulse; a clear in that same cycle wins
   assign flag_view = O_SYS_RESET || flag_reg;
   always @(posedge I_REF_CLK or negedge I_RESET_N)
      if (!I_RESET_N)
         flag_reg <= 1'b0;
      else
         flag_reg <= flag_view && !clr;
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RESET_N);
   a_unmapped_error: assert property (acc && !mapped |-> O_PSLVERR && (I_PWRITE || O_PRDATA == 0))
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (acc && mapped |-> !O_PSLVERR)
      else $error("error on a mapped access");
   a_flag_forces_en: assert property (
      rd && I_PADDR == 12'h000 && $past(flag_view) |-> O_PRDATA[3])
      else $error("reset enable reads low while flag set");
   a_cause_tracks_flag: assert property (
      rd && I_PADDR == 12'h004 |-> O_PRDATA[3] == $past(flag_view))
      else $error("reset flag does not follow watchdog resets");
   a_reset_vector_pulse: assert property (
      O_SYS_RESET |-> O_RESET_VECTOR == 12'h000 ##1 !O_SYS_RESET)
      else $error("bad reset vector or long reset pulse");
   a_irq_vector: assert property (O_WD_IRQ |-> O_TIMEOUT_VECTOR == 12'h006)
      else $error("wrong time-out vector");
   a_osc_quiet: assert property ($stable(I_WD_OSC) [*8] |-> !O_SYS_RESET)
      else $error("reset without oscillator cycles");
   a_read_upper: assert property (rd |-> O_PRDATA[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_restart_zero: assert property (rd && I_PADDR == 12'h008 |-> O_PRDATA == 0)
      else $error("restart register reads nonzero");
   c_irq: cover property ($rose(O_WD_IRQ));
   c_reset: cover property (O_SYS_RESET);
   c_unmapped: cover property (acc && !mapped);
endmodule

bind wdg_top wdg_checker u_chk (.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .I_WD_OSC(I_WD_OSC), .O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA), .O_WD_IRQ(O_WD_IRQ),
   .O_SYS_RESET(O_SYS_RESET), .O_RESET_VECTOR(O_RESET_VECTOR),
   .O_TIMEOUT_VECTOR(O_TIMEOUT_VECTOR));

// [dv/wdg_top_bench.sv]
// self-checking bench for the watchdog top module
`timescale 1ns/1ps
`include "wdg_defines.vh"
module wdg_top_bench;
   localparam int BASE = 4;
   localparam logic [11:0] CT = 12'h000, CA = 12'h004, RS = 12'h008;
   // address, write data, expected read back
   localparam logic [27:0] ROWS [7] = '{{CT, 8'h40, 8'h40}, {CT, 8'h07, 8'h00},
      {CT, 8'h08, 8'h08}, {CT, 8'h00, 8'h08}, {CA, 8'h08, 8'h00}, {RS, 8'hff, 8'h00},
      {12'h00c, 8'hff, 8'h00}};
   logic I_REF_CLK, I_RESET_N, I_PSEL, I_PENABLE, I_PWRITE, I_WD_OSC, I_ALWAYS_ON_FUSE;
   logic I_TIMEOUT_VECTOR_ACK, O_PREADY, O_PSLVERR, O_WD_IRQ, O_SYS_RESET;
   logic [11:0] I_PADDR, O_RESET_VECTOR, O_TIMEOUT_VECTOR;
   logic [31:0] I_PWDATA, O_PRDATA, rdat;
   logic [7:0] cv;
   int n_errors = 0, checked = 0, n_sys = 0, cyc = 0;
   wdg_top #(.WD_BASE_CYCLES(BASE)) uut (.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N),
      .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
      .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA),
      .I_WD_OSC(I_WD_OSC), .I_ALWAYS_ON_FUSE(I_ALWAYS_ON_FUSE), .O_WD_IRQ(O_WD_IRQ),
      .I_TIMEOUT_VECTOR_ACK(I_TIMEOUT_VECTOR_ACK), .O_SYS_RESET(O_SYS_RESET),
      .O_RESET_VECTOR(O_RESET_VECTOR), .O_TIMEOUT_VECTOR(O_TIMEOUT_VECTOR));
   initial
   begin
      I_REF_CLK = 1'b0;
      forever #4 I_REF_CLK = ~I_REF_CLK;
   end
   task summarize;
      begin
         $display("errors %0d, checks %0d", n_errors, checked);
         if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         checked++;
         if (g !== e)
         begin
            n_errors++;
            $display("unexpected at %0t: got %h, want %h", $time, g, e);
         end
      end
   endtask
   task irq(input logic e);
      chk({31'h0, O_WD_IRQ}, {31'h0, e});
   endtask
   // one-cycle pulse of the cpu taking the time-out vector
   task ack;
      begin
         I_TIMEOUT_VECTOR_ACK <= 1'b1;
         @(posedge I_REF_CLK);
         I_TIMEOUT_VECTOR_ACK <= 1'b0;
         @(posedge I_REF_CLK);
      end
   endtask
   task op(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
      begin
         I_PSEL <= 1'b1;
         I_PWRITE <= w;
         I_PADDR <= a;
         I_PWDATA <= {24'h0, d};
         @(posedge I_REF_CLK);
         I_PENABLE <= 1'b1;
         @(posedge I_REF_CLK);
         while (O_PREADY !== 1'b1)
            @(posedge I_REF_CLK);
         rdat = O_PRDATA;
         chk({31'h0, O_PSLVERR}, {31'h0, a > RS});
         I_PSEL <= 1'b0;
         I_PENABLE <= 1'b0;
         @(posedge I_REF_CLK);
         if (!w)
            chk(rdat, {24'h0, e});
      end
   endtask
   // each oscillator cycle spans six clocks, then the action pipeline drains
   task osc(input int n);
      begin
         repeat (n)
         begin
            I_WD_OSC <= 1'b1;
            repeat (3) @(posedge I_REF_CLK);
            I_WD_OSC <= 1'b0;
            repeat (3) @(posedge I_REF_CLK);
         end
         repeat (4) @(posedge I_REF_CLK);
      end
   endtask
   always @(posedge I_REF_CLK)
   begin
      cyc <= cyc + 1;
      if (O_SYS_RESET === 1'b1)
         n_sys <= n_sys + 1;
      if (cyc == 12000)
      begin
         n_errors++;
         summarize;
      end
   end
   initial
   begin
      {I_PSEL, I_PENABLE, I_PWRITE, I_WD_OSC, I_ALWAYS_ON_FUSE, I_TIMEOUT_VECTOR_ACK} = '0;
      I_PADDR = '0;
      I_PWDATA = '0;
      I_RESET_N = 1'b0;
      repeat (12) @(posedge I_REF_CLK);
      I_RESET_N <= 1'b1;
      @(posedge I_REF_CLK);
      chk({20'h0, O_RESET_VECTOR}, 32'h0);
      chk({20'h0, O_TIMEOUT_VECTOR}, 32'h6);
      op(0, CA, 8'h00, 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         op(1, ROWS[i][27:16], ROWS[i][15:8], 8'h00);
         op(0, ROWS[i][27:16], 8'h00, ROWS[i][7:0]);
      end
      op(1, CT, 8'h18, 8'h00);
      op(0, CT, 8'h00, 8'h18);
      repeat (4) @(posedge I_REF_CLK);
      op(0, CT, 8'h00, 8'h08);
      op(1, CT, 8'h18, 8'h00);
      op(1, CT, 8'h21, 8'h00);
      op(0, CT, 8'h00, 8'h21);
      // codes 0 and 8: the latter exercises the split high period bit
      for (int k = 0; k < 2; k++)
      begin
         cv = (k == 0) ? 8'h40 : 8'h60;
         op(1, CT, 8'h18, 8'h00);
         op(1, CT, cv, 8'h00);
         op(1, RS, 8'h00, 8'h00);
         osc((BASE << (k * 8)) - 1);
         irq(1'b0);
         osc(1);
         irq(1'b1);
         if (k == 0)
            op(1, CT, 8'hc0, 8'h00);
         else
            ack;
         irq(1'b0);
         op(0, CT, 8'h00, cv);
      end
      // combined mode: taking the vector drops the irq enable, leaving reset mode
      op(1, CT, 8'h18, 8'h00);
      op(1, CT, 8'h48, 8'h00);
      op(1, RS, 8'h00, 8'h00);
      osc(BASE);
      irq(1'b1);
      ack;
      irq(1'b0);
      op(0, CT, 8'h00, 8'h08);
      op(1, CT, 8'h18, 8'h00);
      op(1, CT, 8'h48, 8'h00);
      op(1, RS, 8'h00, 8'h00);
      osc(BASE);
      irq(1'b1);
      chk(n_sys, 0);
      osc(BASE);
      chk(n_sys, 1);
      op(0, CA, 8'h00, 8'h08);
      op(0, CT, 8'h00, 8'h08);
      op(1, CT, 8'h18, 8'h00);
      op(1, CT, 8'h00, 8'h00);
      op(0, CT, 8'h00, 8'h08);
      op(1, CA, 8'h00, 8'h00);
      op(0, CT, 8'h00, 8'h00);
      I_ALWAYS_ON_FUSE <= 1'b1;
      op(1, RS, 8'h00, 8'h00);
      osc(BASE);
      chk(n_sys, 2);
      I_ALWAYS_ON_FUSE <= 1'b0;
      I_RESET_N <= 1'b0;
      repeat (2) @(posedge I_REF_CLK);
      I_RESET_N <= 1'b1;
      @(posedge I_REF_CLK);
      op(0, CA, 8'h00, 8'h00);
      summarize;
   end
endmodule

// [hdl/wdg_defines.vh]
// register map, field positions and counts of the watchdog block
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

`define WDG_ADDR_W 12
`define WDG_CTRL_ADDR 12'h000
`define WDG_CAUSE_ADDR 12'h004
`define WDG_RESTART_ADDR 12'h008

`define WDG_CTRL_IRQ_FLAG 7
`define WDG_CTRL_IRQ_EN 6
`define WDG_CTRL_PERIOD_HI 5
`define WDG_CTRL_UNLOCK 4
`define WDG_CTRL_RESET_EN 3
`define WDG_CTRL_PERIOD_LO_MSB 2
`define WDG_CAUSE_RESET_FLAG 3

`define WDG_PERIOD_RESET 4'h0
`define WDG_PERIOD_MAX 4'h9
`define WDG_BASE_CYCLES 20'h00800
`define WDG_COUNT_W 20
`define WDG_UNLOCK_CYCLES 3'h4

`define WDG_RESET_VECTOR 12'h000
`define WDG_TIMEOUT_VECTOR 12'h006

`endif

// [hdl/wdg_sync.v]
// two-flop synchroniser for the oscillator and fuse pins
`timescale 1ns/1ps
module wdg_sync
(
   input wire clk,         // system clock
   input wire rst_n,       // async reset, active low
   input wire [1:0] d_in,  // asynchronous levels
   output wire [1:0] q_out // synchronised levels
);
   reg [1:0] meta_reg;
   reg [1:0] sync_reg;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
      end
      else
      begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign q_out = sync_reg;
endmodule

// [hdl/wdg_ticker.v]
// counts watchdog oscillator cycles and flags the selected time-out
`timescale 1ns/1ps
`include "wdg_defines.vh"
module wdg_ticker
#(
   parameter [`WDG_COUNT_W-1:0] BASE_CYCLES = `WDG_BASE_CYCLES
)
(
   input wire clk,          // system clock
   input wire rst_n,        // async reset, active low
   input wire osc_lvl,      // synchronised oscillator level
   input wire run,          // watchdog not stopped
   input wire restart,      // restart count from zero
   input wire [3:0] period, // period select code
   output reg timeout       // one-cycle time-out pulse
);
   reg osc_prev_reg;
   reg [`WDG_COUNT_W-1:0] count_reg;
   wire osc_tick;
   wire [`WDG_COUNT_W-1:0] last;

   // last count value before time-out; reserved codes never expire
   function [`WDG_COUNT_W-1:0] last_count;
      input [3:0] code;
      begin
         if (code > `WDG_PERIOD_MAX)
            last_count = {`WDG_COUNT_W{1'b1}};
         else
            last_count = (BASE_CYCLES << code) - 1'b1;
      end
   endfunction

   assign osc_tick = osc_lvl & ~osc_prev_reg;
   assign last = last_count(period);

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_prev_reg <= 1'b0;
         count_reg <= {`WDG_COUNT_W{1'b0}};
         timeout <= 1'b0;
      end
      else
      begin
         osc_prev_reg <= osc_lvl;
         timeout <= 1'b0;
         if (restart || !run)
            count_reg <= {`WDG_COUNT_W{1'b0}};
         else if (osc_tick)
         begin
            if (count_reg >= last && period <= `WDG_PERIOD_MAX)
            begin
               count_reg <= {`WDG_COUNT_W{1'b0}};
               timeout <= 1'b1;
            end
            else
               count_reg <= count_reg + 1'b1;
         end
      end
   end
endmodule

// [hdl/wdg_top.v]
// watchdog control, reset cause flag and time-out actions with APB slave
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "wdg_defines.vh"
module wdg_top
#(
   parameter [`WDG_COUNT_W-1:0] WD_BASE_CYCLES = `WDG_BASE_CYCLES
)
(
   input wire I_REF_CLK,                     // 125 MHz system clock
   input wire I_RESET_N,                     // power-on reset, active low
   input wire I_PSEL,                        // apb select
   input wire I_PENABLE,                     // apb access phase
   input wire I_PWRITE,                      // apb direction, high for write
   input wire [`WDG_ADDR_W-1:0] I_PADDR,     // apb byte address
   input wire [31:0] I_PWDATA,               // apb write data
   output wire O_PREADY,                     // apb ready
   output wire O_PSLVERR,                    // apb error on unmapped address
   output wire [31:0] O_PRDATA,              // apb read data
   input wire I_WD_OSC,                      // watchdog oscillator pin
   input wire I_ALWAYS_ON_FUSE,              // wd_always_on_fuse, high = programmed
   input wire I_TIMEOUT_VECTOR_ACK,          // cpu executes the time-out vector
   output wire O_WD_IRQ,                     // time-out interrupt request
   output wire O_SYS_RESET,                  // watchdog system reset pulse
   output wire [`WDG_ADDR_W-1:0] O_RESET_VECTOR,  // start address after reset
   output wire [`WDG_ADDR_W-1:0] O_TIMEOUT_VECTOR // wd_timeout_vector address
);
   reg irq_flag_reg;
   reg irq_flag_next;
   reg irq_en_reg;
   reg irq_en_next;
   reg reset_en_reg;
   reg reset_en_next;
   reg [3:0] period_reg;
   reg [3:0] period_next;
   reg unlock_reg;
   reg unlock_next;
   reg [2:0] unlock_cnt_reg;
   reg [2:0] unlock_cnt_next;
   reg reset_flag_reg;
   reg reset_flag_next;
   reg sys_reset_reg;
   reg [31:0] prdata_reg;
   reg [31:0] rd_value;
   reg [`WDG_ADDR_W-1:0] reset_vec_reg;
   reg [`WDG_ADDR_W-1:0] timeout_vec_reg;
   reg [1:0] wd_mode;
   reg act_reset;
   reg act_irq;

   wire [1:0] sync_q;
   wire osc_lvl;
   wire fuse_on;
   wire timeout;
   wire access;
   wire wr_ctrl;
   wire wr_cause;
   wire wr_restart;
   wire mapped;
   wire reset_en_eff;
   wire running;
   wire fire_reset;
   wire fire_irq;
   wire [7:0] ctrl_view;
   wire [3:0] wr_period;
   wire [1:0] reg_hit;

   // timing modes of the watchdog, reset enable in the high bit
   localparam [1:0] MODE_STOPPED = 2'b00;
   localparam [1:0] MODE_IRQ = 2'b01;
   localparam [1:0] MODE_RESET = 2'b10;
   localparam [1:0] MODE_BOTH = 2'b11;

   // register index behind an address; none for unmapped offsets
   localparam [1:0] HIT_NONE = 2'b00;
   localparam [1:0] HIT_CTRL = 2'b01;
   localparam [1:0] HIT_CAUSE = 2'b10;
   localparam [1:0] HIT_RESTART = 2'b11;

   function [1:0] reg_index;
      input [`WDG_ADDR_W-1:0] addr;
      begin
         case (addr)
            `WDG_CTRL_ADDR:
               reg_index = HIT_CTRL;
            `WDG_CAUSE_ADDR:
               reg_index = HIT_CAUSE;
            `WDG_RESTART_ADDR:
               reg_index = HIT_RESTART;
            default:
               reg_index = HIT_NONE;
         endcase
      end
   endfunction

   // both pins are asynchronous to the system clock
   wdg_sync u_sync
   (
      .clk(I_REF_CLK),
      .rst_n(I_RESET_N),
      .d_in({I_ALWAYS_ON_FUSE, I_WD_OSC}),
      .q_out(sync_q)
   );
   assign osc_lvl = sync_q[0];
   assign fuse_on = sync_q[1];

   assign access = I_PSEL & I_PENABLE;
   assign reg_hit = reg_index(I_PADDR);
   assign mapped = (reg_hit != HIT_NONE);
   assign wr_ctrl = access & I_PWRITE & (reg_hit == HIT_CTRL);
   assign wr_cause = access & I_PWRITE & (reg_hit == HIT_CAUSE);
   assign wr_restart = access & I_PWRITE & (reg_hit == HIT_RESTART);

   // period field from bit 5 and bits 2:0
   assign wr_period = {I_PWDATA[`WDG_CTRL_PERIOD_HI], I_PWDATA[`WDG_CTRL_PERIOD_LO_MSB:0]};

   assign reset_en_eff = reset_en_reg | reset_flag_reg | fuse_on;

   // enables pick the mode
   // the fuse wins so that software cannot leave reset mode at all
   always @*
   begin
      if (fuse_on)
         wd_mode = MODE_RESET;
      else
         wd_mode = {reset_en_eff, irq_en_reg};
   end
   assign running = (wd_mode != MODE_STOPPED);

   // mode decides time-out action
   // in MODE_BOTH a second time-out with the interrupt still pending falls through to reset
   always @*
   begin
      act_reset = 1'b0;
      act_irq = 1'b0;
      case (wd_mode)
         MODE_IRQ:
            act_irq = 1'b1;
         MODE_RESET:
            act_reset = 1'b1;
         MODE_BOTH:
         begin
            act_reset = irq_flag_reg;
            act_irq = ~irq_flag_reg;
         end
         default:
         begin
            act_reset = 1'b0;
            act_irq = 1'b0;
         end
      endcase
   end
   assign fire_reset = timeout & act_reset;
   assign fire_irq = timeout & act_irq;

   assign ctrl_view = {irq_flag_reg, irq_en_reg, period_reg[3], unlock_reg,
      reset_en_eff, period_reg[2:0]};

   wdg_ticker #(.BASE_CYCLES(WD_BASE_CYCLES)) u_ticker
   (
      .clk(I_REF_CLK),
      .rst_n(I_RESET_N),
      .osc_lvl(osc_lvl),
      .run(running),
      .restart(wr_restart | fire_reset),
      .period(period_reg),
      .timeout(timeout)
   );

   always @*
   begin
      irq_flag_next = irq_flag_reg;
      irq_en_next = irq_en_reg;
      reset_en_next = reset_en_reg;
      period_next = period_reg;
      unlock_next = unlock_reg;
      unlock_cnt_next = unlock_cnt_reg;
      reset_flag_next = reset_flag_reg;

      // unlock window expires on its own
      if (unlock_reg)
      begin
         if (unlock_cnt_reg == 3'h1)
            unlock_next = 1'b0;
         unlock_cnt_next = unlock_cnt_reg - 3'h1;
      end

      if (wr_ctrl)
      begin
         irq_en_next = I_PWDATA[`WDG_CTRL_IRQ_EN];
         if (I_PWDATA[`WDG_CTRL_RESET_EN])
            reset_en_next = 1'b1;
         // clear or period change only when unlocked
         // reserved period codes are stored but never expire
         if (unlock_reg)
         begin
            reset_en_next = I_PWDATA[`WDG_CTRL_RESET_EN];
            period_next = wr_period;
         end
         if (I_PWDATA[`WDG_CTRL_UNLOCK] && I_PWDATA[`WDG_CTRL_RESET_EN])
         begin
            unlock_next = 1'b1;
            unlock_cnt_next = `WDG_UNLOCK_CYCLES;
         end
         else
            unlock_next = 1'b0;
      end

      // vector or write of one clears
      if (I_TIMEOUT_VECTOR_ACK || (wr_ctrl && I_PWDATA[`WDG_CTRL_IRQ_FLAG]))
         irq_flag_next = 1'b0;
      if (I_TIMEOUT_VECTOR_ACK && reset_en_eff)
         irq_en_next = 1'b0;
      if (fire_irq)
         irq_flag_next = 1'b1;

      if (wr_cause && !I_PWDATA[`WDG_CAUSE_RESET_FLAG])
         reset_flag_next = 1'b0;

      // watchdog reset sets flag
      // control returns to its reset values; enable stays forced via the flag
      if (fire_reset)
      begin
         reset_flag_next = 1'b1;
         irq_flag_next = 1'b0;
         irq_en_next = 1'b0;
         reset_en_next = 1'b0;
         period_next = `WDG_PERIOD_RESET;
         unlock_next = 1'b0;
         unlock_cnt_next = 3'h0;
      end
   end

   always @*
   begin
      rd_value = 32'h0;
      case (reg_hit)
         HIT_CTRL:
            rd_value = {24'h0, ctrl_view};
         HIT_CAUSE:
            rd_value = {28'h0, reset_flag_reg, 3'h0};
         default:
            rd_value = 32'h0;
      endcase
   end

   always @(posedge I_REF_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         irq_flag_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         reset_en_reg <= 1'b0;
         period_reg <= `WDG_PERIOD_RESET;
         unlock_reg <= 1'b0;
         unlock_cnt_reg <= 3'h0;
         reset_flag_reg <= 1'b0;
         sys_reset_reg <= 1'b0;
         prdata_reg <= 32'h0;
         reset_vec_reg <= `WDG_RESET_VECTOR;
         timeout_vec_reg <= `WDG_TIMEOUT_VECTOR;
      end
      else
      begin
         irq_flag_reg <= irq_flag_next;
         irq_en_reg <= irq_en_next;
         reset_en_reg <= reset_en_next;
         period_reg <= period_next;
         unlock_reg <= unlock_next;
         unlock_cnt_reg <= unlock_cnt_next;
         reset_flag_reg <= reset_flag_next;
         // reset pulse, start at vector 0x000
         sys_reset_reg <= fire_reset;
         reset_vec_reg <= `WDG_RESET_VECTOR;
         timeout_vec_reg <= `WDG_TIMEOUT_VECTOR;
         // read data is caught in the setup cycle so it leaves a flop
         if (I_PSEL && !I_PENABLE)
            prdata_reg <= rd_value;
      end
   end

   assign O_PREADY = 1'b1;
   assign O_PSLVERR = access & ~mapped;
   assign O_PRDATA = prdata_reg;
   assign O_WD_IRQ = irq_flag_reg & irq_en_reg;
   assign O_SYS_RESET = sys_reset_reg;
   assign O_RESET_VECTOR = reset_vec_reg;
   assign O_TIMEOUT_VECTOR = timeout_vec_reg;
endmodule
